// ### recorder_power_control.sv
`default_nettype none
// Functional notes
// - Reset pin high: oscillator off, all halted
// - Reset power-down also initialises the controller
// - Reset aborts record or play immediately
// - Power-down drives all memory selects high
// - Power-down removes request input pull-ups
// - Reset power-down drives fixed pin levels
// - Sleep keeps row and transfer strobes high, filters grounded
// - Sleep halts everything without initialising
// - Sleep keeps control state and memory unchanged, except that record/play moves to POST
// - Sleep stops record/play, post-processing after wake
// - Sleep suspends erase, resumes after wake
// - Sleep freezes output settling, continues later
// - Filter and speaker outputs routed per state
// - Recording speaker level follows style select
// - Monitor node from amp or converter
// - Index area takes 64K bits of memory
// - Mode input picks serial memory or ROM
module recorder_power_control #(
   parameter int SETTLE_LEN = recorder_pkg::SETTLE_CYCLES,
   parameter int ERASE_LEN = recorder_pkg::ERASE_CYCLES
) (
   // Clock and bus reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Control pins
   input wire logic reset_pin,
   input wire logic sleep_request_n,
   input wire logic go_pulse_n,
   input wire logic halt_request_n,
   input wire logic erase_request_n,
   input wire logic standby_style_select,
   input wire logic rom_mode_select,
   input wire logic record_select,
   // Power and pull-ups
   output logic oscillator_enable,
   output logic pullup_enable,
   // External memory pins
   output logic [3:0] memory_select_n,
   output logic memory_row_strobe,
   output logic memory_transfer_strobe,
   output logic memory_shift_clock,
   output logic memory_x_address_line,
   output logic memory_y_address_line,
   output logic memory_write_strobe,
   output logic phrase_select_ready,
   // Analog switch selects
   output recorder_pkg::out_route_t speaker_path_output,
   output recorder_pkg::out_route_t filter_to_converter_output,
   output recorder_pkg::mon_route_t analog_monitor_node
);
   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [recorder_pkg::PIN_COUNT-1:0] pins;
   logic [recorder_pkg::PIN_COUNT-1:0] lvl;
   assign pins = {record_select, rom_mode_select, standby_style_select,
      erase_request_n, halt_request_n, go_pulse_n, sleep_request_n,
      reset_pin};

   genvar gi;
   generate
      for (gi = 0; gi < recorder_pkg::PIN_COUNT; gi++) begin : g_sync
         pin_sync #(
            .RESET_VAL(recorder_pkg::PIN_INIT[gi])
         ) u_sync (
            .pclk(pclk),
            .presetn(presetn),
            .pin(pins[gi]),
            .level(lvl[gi])
         );
      end
   endgenerate

   logic reset_level;
   logic sleep_level_n;
   assign reset_level = lvl[recorder_pkg::PIN_RESET];
   assign sleep_level_n = lvl[recorder_pkg::PIN_SLEEP];

   // ------------------------------------------------------------------
   // Request edge detection
   // ------------------------------------------------------------------
   logic [2:0] req_prev;
   logic [2:0] req_now;
   logic go_fall;
   logic halt_fall;
   logic erase_fall;
   assign req_now = {lvl[recorder_pkg::PIN_ERASE],
      lvl[recorder_pkg::PIN_HALT], lvl[recorder_pkg::PIN_GO]};
   assign go_fall = req_prev[0] && !req_now[0];
   assign halt_fall = req_prev[1] && !req_now[1];
   assign erase_fall = req_prev[2] && !req_now[2];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_prev <= 3'h7;
      end else begin
         req_prev <= req_now;
      end
   end

   // ------------------------------------------------------------------
   // Operation sequencer
   // ------------------------------------------------------------------
   recorder_pkg::op_state_t state;
   recorder_pkg::op_state_t next_state;
   logic asleep;
   logic next_asleep;
   logic tmr_load;
   logic [31:0] tmr_value;
   logic tmr_run;
   logic [31:0] tmr_count;
   logic tmr_expired;

   function automatic logic is_timed(recorder_pkg::op_state_t s);
      return s == recorder_pkg::ST_POST || s == recorder_pkg::ST_ERASE ||
         s == recorder_pkg::ST_SETTLE;
   endfunction

   always_comb begin
      next_state = state;
      next_asleep = !sleep_level_n;
      if (reset_level) begin
         next_state = recorder_pkg::ST_OFF;
         next_asleep = 1'b0;
      end else if (!sleep_level_n) begin
         // Record and play stop here; the frozen POST runs on wake-up.
         if (state == recorder_pkg::ST_RECORD ||
            state == recorder_pkg::ST_PLAY ||
            state == recorder_pkg::ST_ROMPLAY) begin
            next_state = recorder_pkg::ST_POST;
         end
      end else begin
         unique case (state)
            recorder_pkg::ST_OFF: next_state = recorder_pkg::ST_IDLE;
            recorder_pkg::ST_IDLE: begin
               if (go_fall) begin
                  if (lvl[recorder_pkg::PIN_ROM]) begin
                     next_state = recorder_pkg::ST_ROMPLAY;
                  end else if (lvl[recorder_pkg::PIN_RECORD]) begin
                     next_state = recorder_pkg::ST_RECORD;
                  end else begin
                     next_state = recorder_pkg::ST_PLAY;
                  end
               end else if (erase_fall) begin
                  next_state = recorder_pkg::ST_ERASE;
               end
            end
            recorder_pkg::ST_RECORD,
            recorder_pkg::ST_PLAY,
            recorder_pkg::ST_ROMPLAY: begin
               if (halt_fall) begin
                  next_state = recorder_pkg::ST_POST;
               end
            end
            recorder_pkg::ST_POST: begin
               if (tmr_expired) begin
                  next_state = recorder_pkg::ST_SETTLE;
               end
            end
            recorder_pkg::ST_SETTLE,
            recorder_pkg::ST_ERASE: begin
               if (tmr_expired) begin
                  next_state = recorder_pkg::ST_IDLE;
               end
            end
         endcase
      end
      // Timer is cleared by reset and loaded on entry to a timed state.
      tmr_load = reset_level ||
         (next_state != state && is_timed(next_state));
      unique case (next_state)
         recorder_pkg::ST_POST: tmr_value = recorder_pkg::POST_CYCLES;
         recorder_pkg::ST_SETTLE: tmr_value = SETTLE_LEN;
         recorder_pkg::ST_ERASE: tmr_value = ERASE_LEN;
         default: tmr_value = 32'h0000_0000;
      endcase
      if (reset_level) begin
         tmr_value = 32'h0000_0000;
      end
      tmr_run = !asleep && sleep_level_n;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= recorder_pkg::ST_OFF;
         asleep <= 1'b0;
      end else begin
         state <= next_state;
         asleep <= next_asleep;
      end
   end

   op_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .load(tmr_load),
      .load_value(tmr_value),
      .run(tmr_run),
      .count(tmr_count),
      .expired(tmr_expired)
   );

   // ------------------------------------------------------------------
   // Pin levels, computed from the next state so they line up with it
   // ------------------------------------------------------------------
   logic [1:0] chip_index;
   logic next_osc;
   logic next_pullup;
   logic [3:0] next_sel_n;
   logic next_row;
   logic next_xfer;
   logic next_shift;
   logic next_x;
   logic next_y;
   logic next_we;
   logic next_ready;
   recorder_pkg::out_route_t next_spk;
   recorder_pkg::out_route_t next_flt;
   recorder_pkg::mon_route_t next_mon;
   logic active;

   always_comb begin
      active = next_state != recorder_pkg::ST_IDLE &&
         next_state != recorder_pkg::ST_OFF &&
         next_state != recorder_pkg::ST_SETTLE;
      next_osc = next_state != recorder_pkg::ST_OFF && !next_asleep;
      next_pullup = next_osc;
      next_sel_n = 4'hF;
      next_row = 1'b1;
      next_xfer = 1'b1;
      next_shift = 1'b1;
      next_x = 1'b1;
      next_y = 1'b0;
      next_we = 1'b1;
      next_ready = 1'b1;
      next_spk = recorder_pkg::ROUTE_GND;
      next_flt = recorder_pkg::ROUTE_GND;
      next_mon = recorder_pkg::MON_NONE;
      if (next_asleep) begin
         // Address, write strobe and ready keep their last levels.
         next_x = memory_x_address_line;
         next_y = memory_y_address_line;
         next_we = memory_write_strobe;
         next_ready = phrase_select_ready;
      end else if (next_state != recorder_pkg::ST_OFF) begin
         if (active) begin
            next_sel_n = ~(4'h1 << chip_index);
            next_row = 1'b0;
            next_shift = ~memory_shift_clock;
            next_x = memory_shift_clock;
            next_y = ~memory_shift_clock;
            next_ready = 1'b0;
            next_we = !(next_state == recorder_pkg::ST_RECORD ||
               next_state == recorder_pkg::ST_ERASE);
         end
         unique case (next_state)
            recorder_pkg::ST_RECORD: begin
               next_flt = recorder_pkg::ROUTE_FILTER;
               next_spk = lvl[recorder_pkg::PIN_STYLE] ?
                  recorder_pkg::ROUTE_SIG_GND :
                  recorder_pkg::ROUTE_GND;
               next_mon = recorder_pkg::MON_INPUT_AMP;
            end
            recorder_pkg::ST_PLAY,
            recorder_pkg::ST_ROMPLAY: begin
               next_flt = recorder_pkg::ROUTE_FILTER;
               next_spk = recorder_pkg::ROUTE_FILTER;
               next_mon = recorder_pkg::MON_DAC;
            end
            default: begin
               next_flt = recorder_pkg::ROUTE_GND;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oscillator_enable <= 1'b0;
         pullup_enable <= 1'b0;
         memory_select_n <= 4'hF;
         memory_row_strobe <= 1'b1;
         memory_transfer_strobe <= 1'b1;
         memory_shift_clock <= 1'b1;
         memory_x_address_line <= 1'b1;
         memory_y_address_line <= 1'b0;
         memory_write_strobe <= 1'b1;
         phrase_select_ready <= 1'b1;
         speaker_path_output <= recorder_pkg::ROUTE_GND;
         filter_to_converter_output <= recorder_pkg::ROUTE_GND;
         analog_monitor_node <= recorder_pkg::MON_NONE;
      end else begin
         oscillator_enable <= next_osc;
         pullup_enable <= next_pullup;
         memory_select_n <= next_sel_n;
         memory_row_strobe <= next_row;
         memory_transfer_strobe <= next_xfer;
         memory_shift_clock <= next_shift;
         memory_x_address_line <= next_x;
         memory_y_address_line <= next_y;
         memory_write_strobe <= next_we;
         phrase_select_ready <= next_ready;
         speaker_path_output <= next_spk;
         filter_to_converter_output <= next_flt;
         analog_monitor_node <= next_mon;
      end
   end

   // ------------------------------------------------------------------
   // APB registers; no wait states, read data is flopped at the end of the setup phase
   // ------------------------------------------------------------------
   logic [31:0] capacity;
   logic [31:0] next_capacity;
   logic [1:0] next_chip_index;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic setup;
   logic wr_en;
   logic mapped;

   always_comb begin
      setup = psel && !penable && !pready;
      wr_en = psel && penable && pready && pwrite && !pslverr;
      mapped = paddr == recorder_pkg::CONTROL_OFFSET ||
         paddr == recorder_pkg::STATUS_OFFSET ||
         paddr == recorder_pkg::CAPACITY_OFFSET ||
         paddr == recorder_pkg::VOICE_CAPACITY_OFFSET;
      next_pready = setup;
      next_pslverr = setup && !mapped;
      next_prdata = 32'h0000_0000;
      if (setup && !pwrite) begin
         unique case (paddr)
            recorder_pkg::CONTROL_OFFSET: next_prdata = {30'h0, chip_index};
            recorder_pkg::STATUS_OFFSET:
               next_prdata = {27'h0, oscillator_enable, asleep, state};
            recorder_pkg::CAPACITY_OFFSET: next_prdata = capacity;
            recorder_pkg::VOICE_CAPACITY_OFFSET:
               next_prdata = capacity - recorder_pkg::INDEX_AREA_KBITS;
            default: next_prdata = 32'h0000_0000;
         endcase
      end
      next_chip_index = chip_index;
      next_capacity = capacity;
      if (wr_en && paddr == recorder_pkg::CONTROL_OFFSET) begin
         next_chip_index = pwdata[recorder_pkg::CHIP_INDEX_LSB +: 2];
      end
      if (wr_en && paddr == recorder_pkg::CAPACITY_OFFSET) begin
         next_capacity = pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         chip_index <= recorder_pkg::CONTROL_RESET;
         capacity <= recorder_pkg::CAPACITY_RESET;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         chip_index <= next_chip_index;
         capacity <= next_capacity;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_rec_or_play;
      state == recorder_pkg::ST_RECORD || state == recorder_pkg::ST_PLAY;
   endsequence

   a_reset_osc_off: assert property (reset_level |=>
      !oscillator_enable && state == recorder_pkg::ST_OFF)
      else $error("oscillator runs under reset pin");
   a_reset_aborts_op: assert property (
      s_rec_or_play ##0 reset_level |=>
      state == recorder_pkg::ST_OFF && tmr_count == 32'h0)
      else $error("reset did not abort operation");
   a_off_selects_high: assert property (
      state == recorder_pkg::ST_OFF |->
      memory_select_n == 4'hF && !pullup_enable)
      else $error("selects or pull-ups wrong in power-down");
   a_off_pin_levels: assert property (
      state == recorder_pkg::ST_OFF |->
      memory_row_strobe && memory_transfer_strobe && memory_shift_clock &&
      memory_x_address_line && memory_write_strobe && phrase_select_ready &&
      !memory_y_address_line &&
      speaker_path_output == recorder_pkg::ROUTE_GND &&
      filter_to_converter_output == recorder_pkg::ROUTE_GND)
      else $error("reset power-down pin levels wrong");
   a_sleep_pin_levels: assert property (asleep |->
      memory_row_strobe && memory_transfer_strobe && memory_shift_clock &&
      memory_select_n == 4'hF && !oscillator_enable &&
      filter_to_converter_output == recorder_pkg::ROUTE_GND)
      else $error("sleep power-down pin levels wrong");
   // On the wake-up cycle the sequencer may move on, so only the cycles
   // with the sleep level still low must freeze everything.
   a_sleep_holds_state: assert property (
      asleep && !sleep_level_n && !reset_level |=>
      $stable(tmr_count) && $stable(state))
      else $error("state moved while asleep");
   a_sleep_stops_op: assert property (s_rec_or_play ##0
      (!sleep_level_n && !reset_level) |=>
      state == recorder_pkg::ST_POST ##1
      (state == recorder_pkg::ST_POST))
      else $error("sleep did not stop record or play");
   a_erase_resumes: assert property (asleep && !sleep_level_n &&
      state == recorder_pkg::ST_ERASE && !reset_level |=>
      state == recorder_pkg::ST_ERASE && $stable(tmr_count))
      else $error("erase lost during sleep");
   a_settle_frozen: assert property (asleep && !reset_level &&
      state == recorder_pkg::ST_SETTLE |=> $stable(tmr_count))
      else $error("settling advanced while asleep");
   a_play_routing: assert property (
      state == recorder_pkg::ST_PLAY |->
      speaker_path_output == recorder_pkg::ROUTE_FILTER &&
      analog_monitor_node == recorder_pkg::MON_DAC)
      else $error("play routing wrong");
   a_record_speaker: assert property (
      state == recorder_pkg::ST_RECORD |->
      analog_monitor_node == recorder_pkg::MON_INPUT_AMP &&
      speaker_path_output == ($past(lvl[recorder_pkg::PIN_STYLE]) ?
      recorder_pkg::ROUTE_SIG_GND : recorder_pkg::ROUTE_GND))
      else $error("record speaker level wrong");
   a_voice_capacity: assert property (setup && !pwrite &&
      paddr == recorder_pkg::VOICE_CAPACITY_OFFSET |=>
      prdata == $past(capacity) - recorder_pkg::INDEX_AREA_KBITS)
      else $error("voice capacity wrong");
endmodule
`default_nettype wire

// ### recorder_pkg.sv
`default_nettype none
package recorder_pkg;
   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0] CONTROL_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] CAPACITY_OFFSET = 8'h08;
   localparam logic [7:0] VOICE_CAPACITY_OFFSET = 8'h0C;
   localparam int CHIP_INDEX_LSB = 0;
   localparam logic [1:0] CONTROL_RESET = 2'h0;
   localparam logic [31:0] CAPACITY_RESET = 32'h0000_2000;
   // Kilobits kept back for the channel index area.
   localparam logic [31:0] INDEX_AREA_KBITS = 32'h0000_0040;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLOCK_MHZ = 100;
   localparam int SETTLE_TIME_MS = 256;
   localparam int ERASE_TIME_MS = 70;
   localparam int POST_TIME_NS = 1000;
   localparam int SETTLE_CYCLES = SETTLE_TIME_MS * CLOCK_MHZ * 1000;
   localparam int ERASE_CYCLES = ERASE_TIME_MS * CLOCK_MHZ * 1000;
   localparam int POST_CYCLES = POST_TIME_NS * CLOCK_MHZ / 1000;

   // ------------------------------------------------------------------
   // Pin synchroniser slots and their levels after reset
   // ------------------------------------------------------------------
   localparam int PIN_COUNT = 8;
   localparam int PIN_RESET = 0;
   localparam int PIN_SLEEP = 1;
   localparam int PIN_GO = 2;
   localparam int PIN_HALT = 3;
   localparam int PIN_ERASE = 4;
   localparam int PIN_STYLE = 5;
   localparam int PIN_ROM = 6;
   localparam int PIN_RECORD = 7;
   localparam logic [7:0] PIN_INIT = 8'h1F;

   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_IDLE = 3'h1,
      ST_RECORD = 3'h3,
      ST_PLAY = 3'h2,
      ST_POST = 3'h6,
      ST_SETTLE = 3'h7,
      ST_ERASE = 3'h5,
      ST_ROMPLAY = 3'h4
   } op_state_t;

   typedef enum logic [1:0] {
      ROUTE_GND = 2'h0,
      ROUTE_SIG_GND = 2'h1,
      ROUTE_FILTER = 2'h2
   } out_route_t;

   typedef enum logic [1:0] {
      MON_NONE = 2'h0,
      MON_INPUT_AMP = 2'h1,
      MON_DAC = 2'h2
   } mon_route_t;
endpackage
`default_nettype wire

// ### pin_sync.sv
`default_nettype none
module pin_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pin and its settled level
   input wire logic pin,
   output logic level
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   logic next_level;

   // The level only moves once the second and third stages agree.
   always_comb begin
      next_stage = {stage[1:0], pin};
      next_level = (stage[1] == stage[2]) ? stage[2] : level;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage <= {3{RESET_VAL}};
         level <= RESET_VAL;
      end else begin
         stage <= next_stage;
         level <= next_level;
      end
   end
endmodule
`default_nettype wire

// ### op_timer.sv
`default_nettype none
module op_timer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic load,
   input wire logic [31:0] load_value,
   input wire logic run,
   // State
   output logic [31:0] count,
   output logic expired
);
   logic [31:0] next_count;

   always_comb begin
      next_count = count;
      if (load) begin
         next_count = load_value;
      end else if (run && count != 32'h0000_0000) begin
         next_count = count - 32'h0000_0001;
      end
   end

   assign expired = (count == 32'h0000_0000);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 32'h0000_0000;
      end else begin
         count <= next_count;
      end
   end
endmodule
`default_nettype wire

// ### memory_model.sv
`default_nettype none
module memory_model (
   // Memory pins
   input wire logic memory_shift_clock,
   input wire logic [3:0] memory_select_n,
   // Bits clocked in while a device is selected
   output int shifts
);
   timeunit 1ns;
   timeprecision 1ps;
   initial shifts = 0;
   // A deselected memory ignores its clock, so only selected shifts count.
   always @(posedge memory_shift_clock) begin
      if (memory_select_n != 4'hF) begin
         shifts++;
      end
   end
endmodule
`default_nettype wire

// ### recorder_power_control_test.sv
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
   miscompares++; $display("wrong value %s exp %0h got %0h", n, e, a); end end
module recorder_power_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic reset_pin = 1, sleep_request_n = 1, go_pulse_n = 1;
   logic halt_request_n = 1, erase_request_n = 1, standby_style_select = 1;
   logic rom_mode_select = 0, record_select = 1, pready, pslverr;
   logic oscillator_enable, pullup_enable, memory_row_strobe;
   logic memory_transfer_strobe, memory_shift_clock, memory_x_address_line;
   logic memory_y_address_line, memory_write_strobe, phrase_select_ready;
   logic [3:0] memory_select_n;
   recorder_pkg::out_route_t speaker_path_output, filter_to_converter_output;
   recorder_pkg::mon_route_t analog_monitor_node;
   int miscompares = 0, comparisons = 0, shifts, n;
   always #5 pclk = ~pclk;
   // The host grounds its clock to the oscillator while it is stopped.
   logic oscillator_input;
   assign oscillator_input = pclk && oscillator_enable;
   recorder_power_control #(.SETTLE_LEN(20), .ERASE_LEN(30)) uut (.pclk,
      .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .reset_pin, .sleep_request_n, .go_pulse_n, .halt_request_n,
      .erase_request_n, .standby_style_select, .rom_mode_select,
      .record_select, .oscillator_enable, .pullup_enable, .memory_select_n,
      .memory_row_strobe, .memory_transfer_strobe, .memory_shift_clock,
      .memory_x_address_line, .memory_y_address_line, .memory_write_strobe,
      .phrase_select_ready, .speaker_path_output, .filter_to_converter_output,
      .analog_monitor_node);
   memory_model mem (.memory_shift_clock, .memory_select_n, .shifts);
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task ws(input logic [3:0] e);
      n = 0;
      do begin
         apb(0, 8'h04, 0);
         n++;
      end while (rd[3:0] !== e && n < 100);
      `CHK("state", e, rd[3:0])
   endtask
   task off_levels;
      `CHK("selects", 4'hF, memory_select_n)
      `CHK("osc pullup", 2'b00, {oscillator_enable, pullup_enable})
      `CHK("osc input", 1'b0, oscillator_input)
      `CHK("pins", 7'h7E, {memory_row_strobe, memory_transfer_strobe,
         memory_shift_clock, memory_x_address_line, memory_write_strobe,
         phrase_select_ready, memory_y_address_line})
      `CHK("routes", 4'h0, {speaker_path_output, filter_to_converter_output})
   endtask
   task sleep_levels;
      `CHK("selects", 4'hF, memory_select_n)
      `CHK("osc pullup", 2'b00, {oscillator_enable, pullup_enable})
      `CHK("strobes", 3'h7, {memory_row_strobe, memory_transfer_strobe,
         memory_shift_clock})
      `CHK("routes", 4'h0, {speaker_path_output, filter_to_converter_output})
   endtask
   task pulse_go;
      go_pulse_n <= 0;
      repeat (6) @(posedge pclk);
      go_pulse_n <= 1;
   endtask
   task t_record;
      ws(4'h0);
      off_levels();
      reset_pin <= 0;
      ws(4'h1);
      pulse_go();
      ws(4'h3);
      `CHK("sel", 4'hE, memory_select_n)
      `CHK("spk", recorder_pkg::ROUTE_SIG_GND, speaker_path_output)
      `CHK("flt", recorder_pkg::ROUTE_FILTER, filter_to_converter_output)
      `CHK("mon", recorder_pkg::MON_INPUT_AMP, analog_monitor_node)
      sleep_request_n <= 0;
      ws(4'hE);
      sleep_levels();
      n = shifts;
      repeat (40) @(posedge pclk);
      `CHK("memory shifts", n, shifts)
      sleep_request_n <= 1;
      ws(4'h7);
      ws(4'h1);
   endtask
   task t_play_reset;
      apb(1, 8'h00, 32'h2);
      record_select <= 0;
      pulse_go();
      ws(4'h2);
      `CHK("sel", 4'hB, memory_select_n)
      `CHK("spk", recorder_pkg::ROUTE_FILTER, speaker_path_output)
      `CHK("mon", recorder_pkg::MON_DAC, analog_monitor_node)
      reset_pin <= 1;
      ws(4'h0);
      off_levels();
      reset_pin <= 0;
      ws(4'h1);
   endtask
   task t_erase;
      erase_request_n <= 0;
      repeat (6) @(posedge pclk);
      erase_request_n <= 1;
      ws(4'h5);
      sleep_request_n <= 0;
      ws(4'hD);
      repeat (60) @(posedge pclk);
      ws(4'hD);
      sleep_request_n <= 1;
      ws(4'h1);
   endtask
   task t_rom_settle;
      rom_mode_select <= 1;
      pulse_go();
      ws(4'h4);
      halt_request_n <= 0;
      repeat (6) @(posedge pclk);
      halt_request_n <= 1;
      ws(4'h7);
      sleep_request_n <= 0;
      ws(4'hF);
      pulse_go();
      repeat (60) @(posedge pclk);
      ws(4'hF);
      sleep_request_n <= 1;
      ws(4'h1);
      // A start pulse given while asleep in idle must not start anything.
      sleep_request_n <= 0;
      ws(4'h9);
      pulse_go();
      sleep_request_n <= 1;
      ws(4'h1);
   endtask
   task t_regs;
      apb(0, 8'h08, 0);
      `CHK("capacity", 32'h0000_2000, rd)
      apb(0, 8'h0C, 0);
      `CHK("voice", 32'h0000_1FC0, rd)
      apb(1, 8'h08, 32'h0000_1000);
      apb(0, 8'h0C, 0);
      `CHK("voice", 32'h0000_0FC0, rd)
      apb(0, 8'h10, 0);
      `CHK("unmapped", 1'b1, err)
   endtask
   task report_and_stop;
      if (miscompares == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      // The reset pin is held high from power-up until initialised.
      repeat (6) @(posedge pclk);
      presetn <= 1;
      t_record();
      t_play_reset();
      t_erase();
      t_rom_settle();
      t_regs();
      report_and_stop();
   end
   initial begin
      #400000;
      miscompares++;
      report_and_stop();
   end
endmodule
`default_nettype wire
